// >>> inc/spsp_defs.vh
/*
 Constants for the shared serial port: register map, field layout, reset values,
 arbiter owner codes and framing timing.
 Assumes a 100 MHz system clock and inclusion by its bare name.
*/
// Contract
// - Port offers 300..9600 baud in six steps, 7/8 data, 1/2 stop, parity, flow.
// - Reset defaults: 300 baud, 7 data, 1 stop, even parity, DTR/DSR, no reservation; aresetn keeps a stored reservation bit.
// - Reservation off: port ownership follows whichever function is communicating.
// - Reservation on: port granted only to printer, other users refused.
// - Reservation setting takes effect only at next power-up.
// - Reserved: screen download and pass-through transfer/monitoring blocked.
// - Reserved: host traffic never switches device into transfer mode.
// - Arbiter checks controller, scanner, printer, pass-through, download in order.
// - Highest enabled function disables all lower-priority functions.
// - Host microcomputer and printer share one framing setting.
// - Real-time alarm printing allowed only when reservation is active.
// - Two-port variant may assign printer to either port.
`ifndef SPSP_DEFS_VH
`define SPSP_DEFS_VH

// ==========================================
// Register byte offsets
`define SPSP_REG_CFG 4'h0
`define SPSP_REG_REQ 4'h4
`define SPSP_REG_STAT 4'h8
`define SPSP_REG_TXD 4'hC

// ==========================================
// Config field positions
`define SPSP_CFG_BAUD_LO 0
`define SPSP_CFG_BAUD_HI 2
`define SPSP_CFG_DATA8 3
`define SPSP_CFG_STOP2 4
`define SPSP_CFG_PAR_LO 5
`define SPSP_CFG_PAR_HI 6
`define SPSP_CFG_XON 7
`define SPSP_CFG_RESV 8
`define SPSP_CFG_PORT 9
`define SPSP_CFG_RESET 10'h000

// ==========================================
// Parity codes
`define SPSP_PAR_EVEN 2'h0
`define SPSP_PAR_ODD 2'h1
`define SPSP_PAR_NONE 2'h2

// ==========================================
// Owner codes, priority order 1..5
`define SPSP_OWN_NONE 3'h0
`define SPSP_OWN_CTRL 3'h1
`define SPSP_OWN_SCAN 3'h2
`define SPSP_OWN_PRN 3'h3
`define SPSP_OWN_PASS 3'h4
`define SPSP_OWN_DL 3'h5

// ==========================================
// Flow characters and timing
`define SPSP_XON 8'h11
`define SPSP_XOFF 8'h13
`define SPSP_CLK_HZ 100000000
`define SPSP_BAUD_MIN 300
`define SPSP_BAUD_STEPS 6

`endif

// >>> core/spsp_baud.v
/*
 Bit-rate tick generator: one pulse per bit time for six rates 300..9600.
 Assumes the selector is stable while a frame is in flight.
*/
module spsp_baud
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Rate select and tick out
   input wire [2:0] sel,
   output reg tick
);
`include "spsp_defs.vh"

// ==========================================
// Divider, doubling rate per step
reg [19:0] cnt_r;
localparam [31:0] DIV_FULL = `SPSP_CLK_HZ / `SPSP_BAUD_MIN;
wire [19:0] div_base = DIV_FULL[19:0]; // Slowest rate still fits 20 bits
wire [19:0] div = div_base >> ((sel < `SPSP_BAUD_STEPS) ? sel : 3'h0);

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      cnt_r <= 20'h00000;
      tick <= 1'b0;
   end
   else if (cnt_r >= div - 20'h00001)
   begin
      cnt_r <= 20'h00000;
      tick <= 1'b1;
   end
   else
   begin
      cnt_r <= cnt_r + 20'h00001;
      tick <= 1'b0;
   end
end
endmodule // spsp_baud

// >>> core/spsp_sync.v
/*
 Two-flop synchroniser bank for pin inputs.
 Assumes inputs are asynchronous levels.
*/
module spsp_sync #(parameter W = 4)
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
// ==========================================
// First stage read only by second
reg [W-1:0] s1_r;
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      s1_r <= {W{1'b1}};
      q <= {W{1'b1}};
   end
   else
   begin
      s1_r <= d;
      q <= s1_r;
   end
end
endmodule // spsp_sync

// >>> core/spsp_top.v
/*
 Shared serial port: AXI4-Lite registers, priority arbiter, printer transmitter
 with flow control, XON/XOFF receive watcher.
 Assumes one 100 MHz clock, aresetn asserted at power-up.
*/
module spsp_top
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Serial pins, port A and port B
   output reg txd_a,
   output reg txd_b,
   input wire rxd_a,
   input wire rxd_b,
   input wire dsr_a,
   input wire dsr_b,
   output reg dtr,
   // Ownership
   output reg [2:0] owner,
   output reg xfer_mode,
   output reg alarm_print_en
);
`include "spsp_defs.vh"

// ==========================================
// Pin synchronisers
wire [3:0] pin_s;
spsp_sync #(.W(4)) u_sync
(
   .aclk(aclk),
   .aresetn(aresetn),
   .d({dsr_b, dsr_a, rxd_b, rxd_a}),
   .q(pin_s)
);

// ==========================================
// Registers
reg [9:0] cfg_r = `SPSP_CFG_RESET; // Pending setup, software written
reg resv_act_r; // Reservation in force since power-up
reg boot_r; // Power-up latch still pending
reg [4:0] req_r; // Function activity: ctrl,scan,prn,pass,dl
reg [7:0] txd_r;
reg tx_pend_r;
reg xoff_r;
reg refused_r;
wire tx_busy;

// Power-up latch of reservation, after reset release only
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      resv_act_r <= 1'b0;
      boot_r <= 1'b1;
   end
   else if (boot_r)
   begin
      resv_act_r <= cfg_r[`SPSP_CFG_RESV];
      boot_r <= 1'b0;
   end
end

// ==========================================
// AXI4-Lite write path, address and data in either order
reg aw_got_r, w_got_r;
reg [3:0] aw_r;
reg [31:0] wd_r;
wire do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
reg [3:0] wst_r;

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 4'h0;
      wd_r <= 32'h00000000;
      wst_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      // Reservation choice survives reset like a stored setting; rest defaults
      cfg_r <= `SPSP_CFG_RESET | (cfg_r & (10'h001 << `SPSP_CFG_RESV));
      req_r <= 5'h00;
      txd_r <= 8'h00;
      tx_pend_r <= 1'b0;
   end
   else
   begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_got_r <= 1'b1;
         aw_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_got_r <= 1'b1;
         wd_r <= s_axi_wdata;
         wst_r <= s_axi_wstrb;
      end
      if (tx_pend_r && tx_busy)
         tx_pend_r <= 1'b0;
      if (do_wr)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= 2'h0;
         case (aw_r)
            `SPSP_REG_CFG:
            begin
               // Reservation bit stored, acted on next power-up
               if (wst_r[0])
                  cfg_r[7:0] <= wd_r[7:0];
               if (wst_r[1])
                  cfg_r[9:8] <= wd_r[9:8];
            end
            `SPSP_REG_REQ:
               if (wst_r[0])
                  req_r <= wd_r[4:0];
            `SPSP_REG_TXD:
               if (wst_r[0] && !tx_pend_r)
               begin
                  txd_r <= wd_r[7:0];
                  tx_pend_r <= 1'b1;
               end
            `SPSP_REG_STAT:
               s_axi_bresp <= 2'h2; // Read-only
            default:
               s_axi_bresp <= 2'h2; // Unmapped
         endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
end

// ==========================================
// Arbiter: printer when reserved, else first enabled function by priority wins
reg [2:0] own_nxt;
always @*
begin
   own_nxt = `SPSP_OWN_NONE;
   if (resv_act_r)
      own_nxt = `SPSP_OWN_PRN;
   else if (req_r[0])
      own_nxt = `SPSP_OWN_CTRL;
   else if (req_r[1])
      own_nxt = `SPSP_OWN_SCAN;
   else if (req_r[2])
      own_nxt = `SPSP_OWN_PRN;
   else if (req_r[3])
      own_nxt = `SPSP_OWN_PASS;
   else if (req_r[4])
      own_nxt = `SPSP_OWN_DL;
end

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      owner <= `SPSP_OWN_NONE;
      xfer_mode <= 1'b0;
      alarm_print_en <= 1'b0;
      refused_r <= 1'b0;
   end
   else
   begin
      owner <= own_nxt;
      // Transfer mode never entered while reserved
      xfer_mode <= !resv_act_r && (own_nxt == `SPSP_OWN_DL);
      alarm_print_en <= resv_act_r;
      // Sticky refusal flag; set wins over read clear
      if (resv_act_r && (req_r[0] || req_r[1] || req_r[3] || req_r[4]))
         refused_r <= 1'b1;
      else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SPSP_REG_STAT)
         refused_r <= 1'b0;
   end
end

// ==========================================
// Baud tick
wire tick;
spsp_baud u_baud
(
   .aclk(aclk),
   .aresetn(aresetn),
   .sel(cfg_r[`SPSP_CFG_BAUD_HI:`SPSP_CFG_BAUD_LO]),
   .tick(tick)
);

// ==========================================
// Transmitter
localparam TX_IDLE = 2'h0;
localparam TX_START = 2'h1;
localparam TX_BITS = 2'h2;
localparam TX_STOP = 2'h3;
reg [1:0] tx_st_r;
reg [7:0] sh_r;
reg [3:0] bit_r;
reg par_r;
reg tx_bit;
wire port_b = cfg_r[`SPSP_CFG_PORT];
wire dsr_sel = port_b ? pin_s[3] : pin_s[2];
wire [1:0] par_mode = cfg_r[`SPSP_CFG_PAR_HI:`SPSP_CFG_PAR_LO];
wire [3:0] nbits = (cfg_r[`SPSP_CFG_DATA8] ? 4'h8 : 4'h7)
                   + ((par_mode == `SPSP_PAR_NONE) ? 4'h0 : 4'h1);
wire [3:0] nstop = cfg_r[`SPSP_CFG_STOP2] ? 4'h2 : 4'h1;
wire flow_ok = cfg_r[`SPSP_CFG_XON] ? !xoff_r : !dsr_sel; // DSR active low on pin
wire prn_own = (owner == `SPSP_OWN_PRN);
assign tx_busy = (tx_st_r != TX_IDLE);

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      tx_st_r <= TX_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      par_r <= 1'b0;
      tx_bit <= 1'b1;
   end
   else if (tick)
   begin
      case (tx_st_r)
         TX_IDLE:
         begin
            tx_bit <= 1'b1;
            // Pause only between characters
            if (tx_pend_r && prn_own && flow_ok)
            begin
               tx_st_r <= TX_START;
               sh_r <= txd_r;
               par_r <= (par_mode == `SPSP_PAR_ODD);
            end
         end
         TX_START:
         begin
            tx_bit <= 1'b0;
            bit_r <= 4'h0;
            tx_st_r <= TX_BITS;
         end
         TX_BITS:
         begin
            if (bit_r == nbits - 4'h1 && par_mode != `SPSP_PAR_NONE)
               tx_bit <= par_r;
            else
            begin
               tx_bit <= sh_r[0];
               par_r <= par_r ^ sh_r[0];
               sh_r <= {1'b0, sh_r[7:1]};
            end
            bit_r <= bit_r + 4'h1;
            if (bit_r == nbits - 4'h1)
            begin
               bit_r <= 4'h0;
               tx_st_r <= TX_STOP;
            end
         end
         TX_STOP:
         begin
            tx_bit <= 1'b1;
            bit_r <= bit_r + 4'h1;
            if (bit_r == nstop)
               tx_st_r <= TX_IDLE;
         end
         default:
            tx_st_r <= TX_IDLE;
      endcase
   end
end

// Pin drive, selected port only
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      txd_a <= 1'b1;
      txd_b <= 1'b1;
      dtr <= 1'b0;
   end
   else
   begin
      txd_a <= port_b ? 1'b1 : tx_bit;
      txd_b <= port_b ? tx_bit : 1'b1;
      dtr <= prn_own;
   end
end

// ==========================================
// Receive watcher for XON/XOFF, sampled on the baud tick
localparam RX_IDLE = 2'h0;
localparam RX_BITS = 2'h1;
reg [1:0] rx_st_r;
reg [7:0] rsh_r;
reg [3:0] rbit_r;
wire rx_in = port_b ? pin_s[1] : pin_s[0];

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      rx_st_r <= RX_IDLE;
      rsh_r <= 8'h00;
      rbit_r <= 4'h0;
      xoff_r <= 1'b0;
   end
   else if (tick)
   begin
      case (rx_st_r)
         RX_IDLE:
            if (!rx_in)
            begin
               rx_st_r <= RX_BITS;
               rbit_r <= 4'h0;
            end
         RX_BITS:
         begin
            rsh_r <= {rx_in, rsh_r[7:1]};
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r == 4'h8)
            begin
               rx_st_r <= RX_IDLE;
               // 7-bit frames mask the parity/top bit
               if ((rsh_r & 8'h7F) == `SPSP_XOFF)
                  xoff_r <= 1'b1;
               else if ((rsh_r & 8'h7F) == `SPSP_XON)
                  xoff_r <= 1'b0;
            end
         end
         default:
            rx_st_r <= RX_IDLE;
      endcase
   end
end

// ==========================================
// AXI4-Lite read path
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
   end
   else
   begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (s_axi_araddr)
            `SPSP_REG_CFG: s_axi_rdata <= {22'h000000, cfg_r};
            `SPSP_REG_REQ: s_axi_rdata <= {27'h0000000, req_r};
            `SPSP_REG_STAT: s_axi_rdata <= {22'h000000, refused_r, xoff_r, tx_pend_r,
                                            tx_busy, xfer_mode, resv_act_r, 1'b0, owner};
            `SPSP_REG_TXD: s_axi_rdata <= {24'h000000, txd_r};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
end
endmodule // spsp_top

// >>> tb/spsp_chk_sva.sv
/*
 Checker for the shared serial port top: ownership outputs and the printer line.
 Assumes a bind to spsp_top, one clock and a synchronous active-low reset.
*/
module spsp_chk
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Watched outputs and pins
   input wire txd_a,
   input wire txd_b,
   input wire dsr_a,
   input wire dtr,
   input wire [2:0] owner,
   input wire xfer_mode,
   input wire alarm_print_en
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Properties
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   reset_idle_a: assert property ($rose(aresetn) |-> owner == 3'h0 && txd_a && txd_b)
      else $error("outputs not idle after reset");
   resv_hold_a: assert property (alarm_print_en |=> alarm_print_en)
      else $error("reservation dropped while running");
   resv_prn_a: assert property (alarm_print_en |-> owner == 3'h3 && !xfer_mode)
      else $error("reserved port not held by printer");
   owner_range_a: assert property (owner <= 3'h5)
      else $error("owner code out of range");
   dl_mode_a: assert property (xfer_mode |-> owner == 3'h5 || $past(owner) == 3'h5)
      else $error("transfer mode without download owner");
   dl_follow_a: assert property (owner == 3'h5 [*3] |-> xfer_mode)
      else $error("download owner but no transfer mode");
   prn_dtr_a: assert property (owner == 3'h3 [*3] |-> dtr)
      else $error("printer owns port but dtr low");
   tx_owner_a: assert property ($fell(txd_a) |-> owner == 3'h3)
      else $error("frame started without printer ownership");
   start_len_a: assert property ($fell(txd_a) |-> !txd_a [*8])
      else $error("start bit too short");
   port_sel_a: assert property (!txd_a |-> txd_b)
      else $error("both ports driven at once");
   dsr_hold_a: assert property (dsr_a [*4] |=> !$fell(txd_a))
      else $error("frame started while printer not ready");

   // Main scenarios reached
   dl_c: cover property (xfer_mode);
   prn_c: cover property (dtr);
   frame_c: cover property ($fell(txd_a));
   resv_c: cover property (alarm_print_en);
endmodule // spsp_chk

// >>> tb/spsp_prn.sv
/*
 Serial printer model: ready line, idle receive line and a mid-bit sampler.
 Assumes the bench sets the bit time to match the port's configured rate.
*/
module spsp_prn #(parameter int BIT = 10416, parameter int NB = 4)
(
   // Clock
   input wire aclk,
   // Line to and from the port
   input wire txd,
   output logic rxd,
   output logic dsr,
   // Bench control and capture
   input wire ready,
   output logic [NB-1:0] bits_r,
   output int got
);
   timeunit 1ns;
   timeprecision 1ps;
   // Ready is low at the pin
   assign dsr = !ready;
   // Line idles at mark; no flow characters are sent
   assign rxd = 1'b1;
   // Start then data bits; framing must equal the port's setting
   initial
   begin
      got = 0;
      bits_r = '0;
      forever
      begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge aclk);
         bits_r[0] = txd;
         for (int i = 1; i < NB; i++)
         begin
            repeat (BIT) @(posedge aclk);
            bits_r[i] = txd;
         end
         got++;
      end
   end
endmodule // spsp_prn

// >>> tb/serial_port_sharing_printer_tb.sv
/*
 Bench for the shared serial port: AXI4-Lite tasks, arbiter, reservation, frame.
 Assumes the printer model and checker compile first; one 100 MHz clock.
*/
`include "spsp_defs.vh"
module serial_port_sharing_printer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, txd_a, txd_b, rxd_a, rxd_b, dsr_a, dsr_b, dtr, xfer_mode;
   logic alarm_print_en, ready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, bits;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] owner;
   int failures = 0, samples_checked = 0, cycles = 0, got;
   logic [4:0] req_t [6] = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00};
   logic [2:0] own_t [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};

   spsp_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd_a, .txd_b,
      .rxd_a, .rxd_b, .dsr_a, .dsr_b, .dtr, .owner, .xfer_mode, .alarm_print_en);
   // Printer on port A at the 9600 baud bit time
   spsp_prn #(.BIT(10416), .NB(4)) prn (.aclk, .txd(txd_a), .rxd(rxd_a), .dsr(dsr_a),
      .ready, .bits_r(bits), .got);

   // ==========================================
   // Clock and hang guard; the whole run needs about 78k cycles
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 96000)
      begin
         failures++;
         test_done();
      end
   end

   // ==========================================
   // Tasks
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Address and data offered together, each dropped when taken
   task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Ownership lags the request write by a few cycles; flags settle after it
   task wait_own(input logic [2:0] e);
      for (int i = 0; i < 20 && owner !== e; i++)
         @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk("owner", owner, e);
   endtask

   // ==========================================
   // Test sequence
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ready} = '0;
      s_axi_wstrb = 4'hF;
      rxd_b = 1'b1;
      dsr_b = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SPSP_REG_CFG, d, r);
      chk("cfg", d, 32'h0);
      rd(`SPSP_REG_STAT, d, r);
      chk("stat owner", d[2:0], 3'h0);
      // Every owner level, highest enabled wins
      for (int i = 0; i < 6; i++)
      begin
         wr(`SPSP_REG_REQ, {27'h0, req_t[i]}, r);
         wait_own(own_t[i]);
         chk("xfer", xfer_mode, own_t[i] == 3'h5);
         chk("dtr", dtr, own_t[i] == 3'h3);
      end
      // Read-only and unmapped places
      wr(`SPSP_REG_STAT, 32'h0, r);
      chk("stat write resp", r, 2'h2);
      rd(4'h2, d, r);
      chk("unmapped resp", r, 2'h2);
      chk("unmapped data", d, 32'h0);
      // Reservation written at run time must not take hold
      wr(`SPSP_REG_CFG, 32'h100, r);
      wr(`SPSP_REG_REQ, 32'h10, r);
      wait_own(3'h5);
      rd(`SPSP_REG_STAT, d, r);
      chk("stat resv xfer", d[5:4], 2'h2);
      chk("alarm", alarm_print_en, 1'b0);
      // Power-up with the stored reservation: printer only
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SPSP_REG_CFG, d, r);
      chk("cfg kept", d, 32'h100);
      wait_own(3'h3);
      chk("alarm resv", alarm_print_en, 1'b1);
      wr(`SPSP_REG_REQ, 32'h11, r);
      wait_own(3'h3);
      chk("xfer resv", xfer_mode, 1'b0);
      rd(`SPSP_REG_STAT, d, r);
      chk("stat refused", d[9:4], 6'h21);
      // Clearing the setting while running leaves the port reserved
      wr(`SPSP_REG_CFG, 32'h0, r);
      wr(`SPSP_REG_REQ, 32'h0, r);
      chk("resv held", alarm_print_en, 1'b1);
      rd(`SPSP_REG_STAT, d, r);
      chk("refused sticky", d[9], 1'b1);
      rd(`SPSP_REG_STAT, d, r);
      chk("refused clear", d[9], 1'b0);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SPSP_REG_CFG, d, r);
      chk("cfg after reset", d, 32'h0);
      chk("alarm off", alarm_print_en, 1'b0);
      // 9600 baud, 8 data, no parity, DTR/DSR; printer busy at first
      wr(`SPSP_REG_CFG, 32'h4D, r);
      wr(`SPSP_REG_REQ, 32'h04, r);
      wait_own(3'h3);
      wr(`SPSP_REG_TXD, 32'hA5, r);
      // Over two bit times, so the port meets the busy printer at a tick
      repeat (23000) @(posedge aclk);
      chk("held line", {txd_a, got[0]}, 2'h2);
      ready <= 1'b1;
      for (int i = 0; i < 70000 && got == 0; i++)
         @(posedge aclk);
      chk("frame head", bits, 4'hA);
      chk("port b idle", txd_b, 1'b1);
      test_done();
   end
endmodule // serial_port_sharing_printer_tb

bind spsp_top spsp_chk chk_i (.aclk, .aresetn, .txd_a, .txd_b, .dsr_a, .dtr, .owner,
   .xfer_mode, .alarm_print_en);
